// [shared/serial_port_regs.vh]
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

// ********************************************************
// Register offsets (byte addresses)
// ********************************************************
`define OFS_CONTROL_STATUS 12'h000
`define OFS_DATA_BUFFER 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_BAUD_DIV 12'h010

// ********************************************************
// Control/status fields
// ********************************************************
`define BIT_FRAME_SIZE 7
`define BIT_MULTIPROC 5
`define BIT_RX_ENABLE 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0

// Interrupt status / mask fields; busy bits are status only
`define IRQ_RX_DONE 0
`define IRQ_TX_DONE 1
`define STAT_TX_BUSY 2
`define STAT_RX_BUSY 3

// ********************************************************
// Reset values and timing
// ********************************************************
`define RST_IRQ_MASK 2'b00
`define RST_BAUD_DIV 16'h0004
`define OVERSAMPLE_LAST 4'hF
`define OVERSAMPLE_HALF 4'h7
`define LAST_IDX_8BIT 4'h8
`define LAST_IDX_9BIT 4'h9

`endif

// [design/baud_tick.v]
// Oversampling tick generator for the serial port
`timescale 1ns/1ps
`default_nettype none
module baud_tick (
    input wire pclk,
    input wire presetn,
    input wire [15:0] divisor,
    output reg tick
);
    // ********************************************************
    // Divider: one tick every divisor+1 clocks
    // ********************************************************
    reg [15:0] count_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 16'h0000;
            tick <= 1'b0;
        end else if (count_r >= divisor) begin
            count_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            count_r <= count_r + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // baud_tick
`default_nettype wire

// [design/serial_port.v]
// Full-duplex 8/9-bit asynchronous serial port with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.vh"
module serial_port (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire serial_rx_pin,
    output reg serial_tx_pin,
    output reg irq
);
    localparam TX_IDLE = 2'd0;
    localparam TX_DATA = 2'd1;
    localparam TX_STOP = 2'd2;
    localparam RX_IDLE = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_BITS = 2'd2;

    // ********************************************************
    // Software-visible state
    // ********************************************************
    reg frame_size_select_r;
    reg multiproc_enable_r;
    reg rx_enable_bit_r;
    reg tx_ninth_bit_r;
    reg rx_ninth_bit_r;
    reg tx_done_flag_r;
    reg rx_done_flag_r;
    reg [7:0] rx_buf_r;
    reg [1:0] irq_mask_r;
    reg [15:0] baud_div_r;

    reg [1:0] tx_state_r;
    reg [9:0] tx_shift_r;
    reg [3:0] tx_idx_r;
    reg [3:0] tx_phase_r;
    reg tx_frame9_r;

    reg [1:0] rx_state_r;
    reg [9:0] rx_bits_r;
    reg [3:0] rx_idx_r;
    reg [3:0] rx_phase_r;
    reg rx_frame9_r;
    reg rx_prev_r;

    wire tick;
    wire access;
    wire wr_en;
    wire wr_ctrl;
    wire wr_data;
    wire wr_irq;
    wire mapped;
    wire tx_start;
    wire tx_set;
    wire rx_set;
    wire tx_clr;
    wire rx_clr;
    wire rx_last_sample;
    wire rx_stop_val;
    wire rx_accept;
    wire [3:0] tx_last;
    wire [3:0] rx_last;
    wire wr_mask;
    wire wr_baud;
    wire tx_busy;
    wire rx_busy;
    wire tx_done_nxt;
    wire rx_done_nxt;
    wire [1:0] irq_mask_nxt;
    reg [31:0] rd_mux;

    baud_tick u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .divisor(baud_div_r),
        .tick(tick)
    );

    // ********************************************************
    // APB slave: one wait-free access phase
    // ********************************************************
    assign access = psel & penable & pready;
    assign wr_en = access & pwrite;
    assign wr_ctrl = wr_en & (paddr == `OFS_CONTROL_STATUS);
    assign wr_data = wr_en & (paddr == `OFS_DATA_BUFFER);
    assign wr_irq = wr_en & (paddr == `OFS_IRQ_STATUS);
    // Strobes for the remaining writable registers
    assign wr_mask = wr_en & (paddr == `OFS_IRQ_MASK);
    assign wr_baud = wr_en & (paddr == `OFS_BAUD_DIV);
    assign mapped = (paddr == `OFS_CONTROL_STATUS) | (paddr == `OFS_DATA_BUFFER) |
                    (paddr == `OFS_IRQ_STATUS) | (paddr == `OFS_IRQ_MASK) |
                    (paddr == `OFS_BAUD_DIV);

    // Flags clear by writing one, through either register
    assign tx_clr = (wr_ctrl & pwdata[`BIT_TX_DONE]) | (wr_irq & pwdata[`IRQ_TX_DONE]);
    assign rx_clr = (wr_ctrl & pwdata[`BIT_RX_DONE]) | (wr_irq & pwdata[`IRQ_RX_DONE]);

    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFS_CONTROL_STATUS: begin
                rd_mux[`BIT_FRAME_SIZE] = frame_size_select_r;
                rd_mux[`BIT_MULTIPROC] = multiproc_enable_r;
                rd_mux[`BIT_RX_ENABLE] = rx_enable_bit_r;
                rd_mux[`BIT_TX_NINTH] = tx_ninth_bit_r;
                rd_mux[`BIT_RX_NINTH] = rx_ninth_bit_r;
                rd_mux[`BIT_TX_DONE] = tx_done_flag_r;
                rd_mux[`BIT_RX_DONE] = rx_done_flag_r;
            end
            `OFS_DATA_BUFFER: rd_mux[7:0] = rx_buf_r;
            `OFS_IRQ_STATUS: begin
                rd_mux[`IRQ_RX_DONE] = rx_done_flag_r;
                rd_mux[`IRQ_TX_DONE] = tx_done_flag_r;
                rd_mux[`STAT_TX_BUSY] = tx_busy;
                rd_mux[`STAT_RX_BUSY] = rx_busy;
            end
            `OFS_IRQ_MASK: rd_mux[1:0] = irq_mask_r;
            `OFS_BAUD_DIV: rd_mux[15:0] = baud_div_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            // Answer registered in setup so outputs stay flop-driven
            pready <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~mapped;
            if (psel & ~penable & ~pready & ~pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_size_select_r <= 1'b0;
            multiproc_enable_r <= 1'b0;
            rx_enable_bit_r <= 1'b0;
            tx_ninth_bit_r <= 1'b0;
            irq_mask_r <= `RST_IRQ_MASK;
            baud_div_r <= `RST_BAUD_DIV;
        end else begin
            if (wr_ctrl) begin
                frame_size_select_r <= pwdata[`BIT_FRAME_SIZE];
                multiproc_enable_r <= pwdata[`BIT_MULTIPROC];
                rx_enable_bit_r <= pwdata[`BIT_RX_ENABLE];
                tx_ninth_bit_r <= pwdata[`BIT_TX_NINTH];
            end
            if (wr_mask) begin
                irq_mask_r <= irq_mask_nxt;
            end
            if (wr_baud) begin
                baud_div_r <= pwdata[15:0];
            end
        end
    end

    // ********************************************************
    // Flags and interrupt
    // ********************************************************
    // Set beats a same-cycle clear; only software clears
    assign tx_done_nxt = tx_set | (tx_done_flag_r & ~tx_clr);
    assign rx_done_nxt = rx_set | (rx_done_flag_r & ~rx_clr);
    // Mask taken at its write edge, so masking drops irq with the access
    assign irq_mask_nxt = wr_mask ? pwdata[1:0] : irq_mask_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done_flag_r <= 1'b0;
            rx_done_flag_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            tx_done_flag_r <= tx_done_nxt;
            rx_done_flag_r <= rx_done_nxt;
            irq <= (tx_done_nxt & irq_mask_nxt[`IRQ_TX_DONE]) |
                   (rx_done_nxt & irq_mask_nxt[`IRQ_RX_DONE]);
        end
    end

    // ********************************************************
    // Transmitter
    // ********************************************************
    // ********************************************************
    // Busy status
    // ********************************************************
    // Software polls these to pace data writes
    assign tx_busy = (tx_state_r != TX_IDLE);
    assign rx_busy = (rx_state_r != RX_IDLE);

    // Write while busy is dropped rather than corrupting the frame
    assign tx_start = wr_data & ~tx_busy;
    assign tx_last = tx_frame9_r ? `LAST_IDX_9BIT : `LAST_IDX_8BIT;
    assign tx_set = (tx_state_r == TX_DATA) & tick & (tx_phase_r == `OVERSAMPLE_LAST) &
                    (tx_idx_r == tx_last);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= TX_IDLE;
            tx_shift_r <= 10'h3FF;
            tx_idx_r <= 4'h0;
            tx_phase_r <= 4'h0;
            tx_frame9_r <= 1'b0;
            serial_tx_pin <= 1'b1;
        end else begin
            case (tx_state_r)
                TX_IDLE: begin
                    serial_tx_pin <= 1'b1;
                    if (tx_start) begin
                        // Start bit, LSB-first data, ninth bit
                        tx_shift_r <= {tx_ninth_bit_r, pwdata[7:0], 1'b0};
                        // Latched so a mode write mid-frame cannot tear it
                        tx_frame9_r <= frame_size_select_r;
                        tx_idx_r <= 4'h0;
                        tx_phase_r <= 4'h0;
                        serial_tx_pin <= 1'b0;
                        tx_state_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tick) begin
                        tx_phase_r <= tx_phase_r + 4'h1;
                        if (tx_phase_r == `OVERSAMPLE_LAST) begin
                            if (tx_idx_r == tx_last) begin
                                serial_tx_pin <= 1'b1;
                                tx_state_r <= TX_STOP;
                            end else begin
                                tx_idx_r <= tx_idx_r + 4'h1;
                                tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                                serial_tx_pin <= tx_shift_r[1];
                            end
                        end
                    end
                end
                TX_STOP: begin
                    serial_tx_pin <= 1'b1;
                    if (tick) begin
                        tx_phase_r <= tx_phase_r + 4'h1;
                        if (tx_phase_r == `OVERSAMPLE_LAST) begin
                            tx_state_r <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_r <= TX_IDLE;
                    serial_tx_pin <= 1'b1;
                end
            endcase
        end
    end

    // ********************************************************
    // Receiver
    // ********************************************************
    assign rx_last = rx_frame9_r ? `LAST_IDX_9BIT : `LAST_IDX_8BIT;
    assign rx_last_sample = (rx_state_r == RX_BITS) & tick &
                            (rx_phase_r == `OVERSAMPLE_LAST) & (rx_idx_r == rx_last);
    // In 9-bit frames the multiprocessor check looks at the ninth bit
    assign rx_stop_val = rx_frame9_r ? rx_bits_r[8] : serial_rx_pin;
    // Full buffer rejects the new frame, so the first byte survives
    assign rx_accept = ~rx_done_flag_r & (~multiproc_enable_r | rx_stop_val);
    assign rx_set = rx_last_sample & rx_accept;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_r <= 8'h00;
            rx_ninth_bit_r <= 1'b0;
        end else if (rx_set) begin
            rx_buf_r <= rx_bits_r[7:0];
            // Ninth bit in 9-bit frames, stop bit otherwise
            rx_ninth_bit_r <= rx_frame9_r ? rx_bits_r[8] : serial_rx_pin;
        end
        // No load at all when rejected
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= RX_IDLE;
            rx_bits_r <= 10'h000;
            rx_idx_r <= 4'h0;
            rx_phase_r <= 4'h0;
            rx_frame9_r <= 1'b0;
            rx_prev_r <= 1'b1;
        end else begin
            rx_prev_r <= serial_rx_pin;
            case (rx_state_r)
                RX_IDLE: begin
                    // Falling edge of the idle-high line
                    if (rx_enable_bit_r & rx_prev_r & ~serial_rx_pin) begin
                        rx_state_r <= RX_START;
                        rx_phase_r <= 4'h0;
                        rx_idx_r <= 4'h0;
                        rx_frame9_r <= frame_size_select_r;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        rx_phase_r <= rx_phase_r + 4'h1;
                        if (rx_phase_r == `OVERSAMPLE_HALF) begin
                            // Glitch shorter than half a bit is not a start
                            if (serial_rx_pin) begin
                                rx_state_r <= RX_IDLE;
                            end else begin
                                rx_phase_r <= 4'h0;
                                rx_state_r <= RX_BITS;
                            end
                        end
                    end
                end
                RX_BITS: begin
                    if (tick) begin
                        rx_phase_r <= rx_phase_r + 4'h1;
                        // A full bit after mid start lands mid bit
                        if (rx_phase_r == `OVERSAMPLE_LAST) begin
                            rx_bits_r[rx_idx_r] <= serial_rx_pin;
                            rx_idx_r <= rx_idx_r + 4'h1;
                            if (rx_idx_r == rx_last) begin
                                rx_state_r <= RX_IDLE;
                            end
                        end
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end
endmodule // serial_port
`default_nettype wire

// [verification/serial_port_asserts.sv]
// Port-level checks on the serial port: APB handshake, line timing, interrupt drop only after a write
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_tx_pin,
    input wire logic irq
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (setup_s |=> pready)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (access_s |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("error read not zero");
    a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_irq_fall_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("interrupt dropped without write");
    // Bit time is at least 16 clocks, so any level must hold 8 cycles
    a_low_bit_hold: assert property ($fell(serial_tx_pin) |-> !serial_tx_pin [*8])
        else $error("low bit too short");
    a_high_bit_hold: assert property ($rose(serial_tx_pin) |=> $stable(serial_tx_pin) [*7])
        else $error("high bit too short");
endmodule // serial_port_checker
bind serial_port serial_port_checker u_serial_port_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_tx_pin(serial_tx_pin), .irq(irq)
);
`default_nettype wire

// [verification/remote_node.sv]
// Remote serial node: sends frames to the port and decodes what it transmits
`timescale 1ns/1ps
`default_nettype none
module remote_node (
    input wire logic pclk,
    input wire logic nine,
    input wire logic tx_line,
    output logic rx_line,
    output logic [9:0] fr_word,
    output logic fr_valid
);
    localparam int BIT_CLKS = 16;
    initial begin
        rx_line = 1'b1;
        fr_valid = 1'b0;
    end
    // Line returns high after the stop bit, never left at the stop level
    task automatic send(input logic [7:0] d, input logic n9, input logic st);
        logic [10:0] f;
        int n;
        f = nine ? {st, n9, d, 1'b0} : {1'b0, st, d, 1'b0};
        n = nine ? 11 : 10;
        for (int k = 0; k < n; k++) begin
            @(posedge pclk);
            rx_line <= f[k];
            repeat (BIT_CLKS - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rx_line <= 1'b1;
        repeat (BIT_CLKS) @(posedge pclk);
    endtask
    // Mid-bit sampling, LSB first
    always begin
        logic [9:0] sh;
        @(negedge tx_line);
        sh = 10'h000;
        repeat (BIT_CLKS / 2) @(posedge pclk);
        for (int k = 0; k < (nine ? 10 : 9); k++) begin
            repeat (BIT_CLKS) @(posedge pclk);
            sh[k] = tx_line;
        end
        fr_word <= sh;
        fr_valid <= 1'b1;
        @(posedge pclk);
        fr_valid <= 1'b0;
    end
endmodule // remote_node
`default_nettype wire

// [verification/async_serial_port_8_9_bit_bench.sv]
// Self-checking bench for the serial port: APB master, remote node, result queues
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_8_9_bit_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic nine = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    wire logic [31:0] prdata;
    wire logic [9:0] fr_word;
    wire logic pready, pslverr, rx_line, serial_tx_pin, irq, fr_valid;
    logic [33:0] exp_rd[$];
    logic [9:0] exp_fr[$];
    logic [7:0] v [10];
    int errors = 0;
    int checked = 0;
    always #50 pclk = ~pclk;
    serial_port u_serial_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_rx_pin(rx_line), .serial_tx_pin(serial_tx_pin), .irq(irq));
    remote_node u_remote_node (.pclk(pclk), .nine(nine), .tx_line(serial_tx_pin),
        .rx_line(rx_line), .fr_word(fr_word), .fr_valid(fr_valid));
    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task cmp(input string n, input logic [33:0] e, input logic [33:0] s);
        checked++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp("read irq/err/data", exp_rd.pop_front(), {irq, pslverr, prdata});
        if (fr_valid === 1'b1)
            cmp("frame", 34'(exp_fr.pop_front()), 34'(fr_word));
    end
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask
    task rd(input logic [11:0] a, input logic [1:0] f, input logic [7:0] d);
        exp_rd.push_back({f, 24'h00_0000, d});
        apb(a, 1'b0, 8'h00);
    endtask
    task give_verdict;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        errors++;
        give_verdict;
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(23834));
        foreach (v[n]) v[n] = 8'($urandom);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 2'b00, 8'h00);
        rd(12'h00C, 2'b00, 8'h00);
        rd(12'h010, 2'b00, 8'h04);
        rd(12'h020, 2'b01, 8'h00);
        wr(12'h010, 8'h00);
        wr(12'h00C, 8'h03);
        wr(12'h000, 8'h10);
        exp_fr.push_back({2'b01, v[0]});
        fork
            begin
                wr(12'h004, v[0]);
                rd(12'h008, 2'b00, 8'h0C);
            end
            u_remote_node.send(v[1], 1'b0, 1'b1);
        join
        rd(12'h000, 2'b10, 8'h17);
        rd(12'h004, 2'b10, v[1]);
        u_remote_node.send(v[2], 1'b0, 1'b1);
        rd(12'h004, 2'b10, v[1]);
        rd(12'h000, 2'b10, 8'h17);
        wr(12'h000, 8'h13);
        rd(12'h000, 2'b00, 8'h14);
        wr(12'h000, 8'h30);
        u_remote_node.send(v[3], 1'b0, 1'b0);
        rd(12'h000, 2'b00, 8'h34);
        rd(12'h004, 2'b00, v[1]);
        wr(12'h000, 8'h00);
        u_remote_node.send(v[4], 1'b0, 1'b1);
        rd(12'h000, 2'b00, 8'h04);
        nine <= 1'b1;
        wr(12'h000, 8'h98);
        exp_fr.push_back({2'b11, v[5]});
        fork
            wr(12'h004, v[5]);
            u_remote_node.send(v[6], 1'b0, 1'b0);
        join
        rd(12'h000, 2'b10, 8'h9B);
        rd(12'h004, 2'b10, v[6]);
        wr(12'h000, 8'hB3);
        u_remote_node.send(v[7], 1'b0, 1'b1);
        rd(12'h000, 2'b00, 8'hB0);
        exp_fr.push_back({2'b10, v[8]});
        fork
            wr(12'h004, v[8]);
            u_remote_node.send(v[9], 1'b1, 1'b1);
        join
        rd(12'h000, 2'b10, 8'hB7);
        rd(12'h004, 2'b10, v[9]);
        wr(12'h00C, 8'h00);
        rd(12'h000, 2'b00, 8'hB7);
        wr(12'h00C, 8'h02);
        wr(12'h008, 8'h01);
        rd(12'h000, 2'b10, 8'hB6);
        rd(12'h008, 2'b10, 8'h02);
        wr(12'h008, 8'h02);
        rd(12'h000, 2'b00, 8'hB4);
        give_verdict;
    end
endmodule // async_serial_port_8_9_bit_bench
`default_nettype wire
